/* logic/card_sideband.sv */
// Sideband pins of a removable SATA card: indicators, write protect,
// card sense and the deep PHY power-off sequence.
// Assumes all inputs synchronous to mclk; the PHY reports its states.
`timescale 1ns/1ps
`default_nettype none
module card_sideband
  import sideband_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_LOW_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        drive_active_signal,
  input  wire logic        link_active,
  input  wire logic        write_cmd_valid,
  input  wire logic        write_protect_in,
  input  wire logic        card_sense_in,
  input  wire logic        phy_in_slumber,
  input  wire logic        phy_ready,
  input  wire logic        phy_powered,
  input  wire logic        device_power_state,
  output var  logic        activity_indicator_out,
  output var  logic        activity_indicator_oe,
  output var  logic        link_indicator_out,
  output var  logic        link_indicator_oe,
  output var  logic        write_reject,
  output var  logic        write_protected,
  output var  logic        deep_phy_off,
  output var  logic        phy_power_down,
  output var  logic        phy_keep_calibration,
  output var  logic        comwake_request,
  output var  logic        device_power_hold,
  output var  logic [15:0] identify_word_161
);
  phy_state_t  state;
  phy_state_t  next_state;
  logic        sense_low;
  logic        timer_enable;
  logic        wake_valid;
  logic        slumber_entry;
  logic        slumber_lost;
  logic        deep_entry;
  logic        phy_returned;
  logic        link_restored;
  logic        next_write_reject;
  logic        next_write_protected;
  logic        next_deep;
  logic        next_power_down;
  logic        next_keep_calibration;
  logic        next_comwake;
  logic        next_power_hold;
  logic [15:0] next_identify;

  // Same one-hot decode feeds the timer and the phy outputs
  function automatic logic in_deep
  (
    input phy_state_t s
  );
    return s == ST_DEEP_OFF;
  endfunction : in_deep

  // Woken PHY must be powered and settled in Slumber first
  function automatic logic phy_back
  (
    input logic powered,
    input logic slumber
  );
    return powered && slumber;
  endfunction : phy_back

  // Reject needs a write command while the protect pin is low
  function automatic logic write_blocked
  (
    input logic write_cmd,
    input logic protect_n
  );
    return write_cmd && !protect_n;
  endfunction : write_blocked

  // Support flag decides the word; bit 0 is the deep power-off flag
  function automatic logic [15:0] identify_value
  (
    input logic supported
  );
    return supported ? ID_WORD_DEEP : ID_WORD_NONE;
  endfunction : identify_value

  // Card-sense is input only; nothing here can drive it
  assign sense_low    = !card_sense_in;
  assign timer_enable = in_deep(state);

  od_pin u_activity
  (
    .mclk       (mclk),
    .resetn     (resetn),
    .assert_low (drive_active_signal),
    .pin_out    (activity_indicator_out),
    .pin_oe     (activity_indicator_oe)
  );

  od_pin u_link
  (
    .mclk       (mclk),
    .resetn     (resetn),
    .assert_low (link_active),
    .pin_out    (link_indicator_out),
    .pin_oe     (link_indicator_oe)
  );

  // Counter only runs in deep off, so normal-operation lows cost nothing
  low_timer #(
    .LIMIT (WAKE_CYCLES)
  ) u_timer
  (
    .mclk      (mclk),
    .resetn    (resetn),
    .enable    (timer_enable),
    .level_low (sense_low),
    .reached   (wake_valid)
  );

  // Transition conditions, named so the case below reads as a table
  always_comb
  begin
    slumber_entry = phy_in_slumber;
    slumber_lost  = !phy_in_slumber;
    deep_entry    = SUPPORT_DEEP && !sense_low;
    phy_returned  = phy_back(phy_powered, phy_in_slumber);
    link_restored = phy_ready;
  end

  // Write-protect group; reject is registered, high one cycle after every cycle of write command while the protect pin is low
  always_comb
  begin
    next_write_protected = !write_protect_in;
    next_write_reject    = write_blocked(write_cmd_valid,
                                         write_protect_in);
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      write_reject    <= 1'b0;
      write_protected <= 1'b0;
    end
    else
    begin
      write_reject    <= next_write_reject;
      write_protected <= next_write_protected;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
      begin
        if (slumber_entry)
        begin
          next_state = ST_SLUMBER;
        end
      end

      ST_SLUMBER:
      begin
        // Host raises sense only after Slumber is reached
        if (slumber_lost)
        begin
          next_state = ST_ACTIVE;
        end
        else if (deep_entry)
        begin
          next_state = ST_DEEP_OFF;
        end
      end

      ST_DEEP_OFF:
      begin
        // Short presence pulses never reach the limit
        if (wake_valid)
        begin
          next_state = ST_POWER_UP;
        end
      end

      ST_POWER_UP:
      begin
        if (phy_returned)
        begin
          next_state = ST_WAKE;
        end
      end

      ST_WAKE:
      begin
        if (link_restored)
        begin
          next_state = ST_ACTIVE;
        end
      end

      default:
      begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state <= ST_ACTIVE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Phy group leads from next_state so no output lags the state
  always_comb
  begin
    next_deep             = in_deep(next_state);
    next_power_down       = next_deep;
    next_keep_calibration = next_deep;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      deep_phy_off         <= 1'b0;
      phy_power_down       <= 1'b0;
      phy_keep_calibration <= 1'b0;
    end
    else
    begin
      deep_phy_off         <= next_deep;
      phy_power_down       <= next_power_down;
      phy_keep_calibration <= next_keep_calibration;
    end
  end

  // COMWAKE is a one-cycle strobe; the PHY times the burst itself
  always_comb
  begin
    next_comwake = (state == ST_POWER_UP) && phy_returned;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      comwake_request <= 1'b0;
    end
    else
    begin
      comwake_request <= next_comwake;
    end
  end

  // Device group; nothing in the phy path feeds these
  always_comb
  begin
    next_power_hold = device_power_state;
    next_identify   = identify_value(SUPPORT_DEEP);
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      device_power_hold <= 1'b0;
      identify_word_161 <= ID_WORD_NONE;
    end
    else
    begin
      device_power_hold <= next_power_hold;
      identify_word_161 <= next_identify;
    end
  end
endmodule : card_sideband
`default_nettype wire

/* logic/sideband_pkg.sv */
// Constants for the card sideband pin logic.
// Assumes a single 20 MHz clock domain.
package sideband_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned WAKE_LOW_MS    = 2;
  localparam int unsigned WAKE_LOW_CYC   = (CLK_HZ / 1000) * WAKE_LOW_MS;
  localparam int unsigned CNT_W          = 17;
  localparam logic        SUPPORT_DEEP   = 1'b1;
  localparam int unsigned ID_WORD_INDEX  = 161;
  localparam logic [15:0] ID_WORD_DEEP   = 16'h0001;
  localparam logic [15:0] ID_WORD_NONE   = 16'h0000;

  typedef enum logic [4:0]
  {
    ST_ACTIVE   = 5'h01,
    ST_SLUMBER  = 5'h02,
    ST_DEEP_OFF = 5'h04,
    ST_POWER_UP = 5'h08,
    ST_WAKE     = 5'h10
  } phy_state_t;
endpackage : sideband_pkg

/* logic/low_timer.sv */
// Times a low level on the card-sense input.
// Assumes the input is synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module low_timer
  import sideband_pkg::*;
#(
  parameter int unsigned LIMIT = WAKE_LOW_CYC
)
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic level_low,
  output var  logic reached
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_reached;

  always_comb
  begin
    next_count   = '0;
    next_reached = 1'b0;
    if (enable && level_low)
    begin
      // Saturates so a long hold stays valid
      if (count >= CNT_W'(LIMIT - 1))
      begin
        next_count   = count;
        next_reached = 1'b1;
      end
      else
      begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      count   <= '0;
      reached <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      reached <= next_reached;
    end
  end
endmodule : low_timer
`default_nettype wire

/* logic/od_pin.sv */
// Open-drain pin driver: only ever drives low.
// Assumes an external or internal weak pull-up for high.
`timescale 1ns/1ps
`default_nettype none
module od_pin
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic assert_low,
  output var  logic pin_out,
  output var  logic pin_oe
);
  logic next_oe;

  always_comb
  begin
    next_oe = assert_low;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
    else
    begin
      pin_out <= 1'b0;
      pin_oe  <= next_oe;
    end
  end
endmodule : od_pin
`default_nettype wire

/* test/sideband_assertions.sv */
// Port-level checks for card_sideband.
// Assumes binding onto the top module, sim WAKE_CYCLES of 8.
`timescale 1ns/1ps
`default_nettype none
module sideband_checker
#(
  parameter int unsigned WAKE_CYCLES = 8
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic drive_active_signal,
  input wire logic link_active,
  input wire logic write_cmd_valid,
  input wire logic write_protect_in,
  input wire logic card_sense_in,
  input wire logic phy_in_slumber,
  input wire logic phy_powered,
  input wire logic device_power_state,
  input wire logic activity_indicator_out,
  input wire logic activity_indicator_oe,
  input wire logic link_indicator_out,
  input wire logic link_indicator_oe,
  input wire logic write_reject,
  input wire logic write_protected,
  input wire logic deep_phy_off,
  input wire logic phy_power_down,
  input wire logic phy_keep_calibration,
  input wire logic comwake_request,
  input wire logic device_power_hold
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Short burst is below the sim wake count of 8
  sequence short_low;
    deep_phy_off && card_sense_in ##1 !card_sense_in[*4] ##1 card_sense_in;
  endsequence
  sequence held_low;
    deep_phy_off ##0 !card_sense_in[*8];
  endsequence
  act_follow_a: assert property ($past(resetn) |->
    activity_indicator_oe == $past(drive_active_signal))
    else $error("activity indicator off its cause");
  link_follow_a: assert property ($past(resetn) |->
    link_indicator_oe == $past(link_active))
    else $error("link indicator off its cause");
  drive_low_a: assert property (!activity_indicator_out &&
    !link_indicator_out) else $error("indicator driven high");
  wp_reject_a: assert property (write_cmd_valid && !write_protect_in
    |=> write_reject) else $error("write not rejected");
  wp_pass_a: assert property (write_protect_in |=> !write_reject)
    else $error("write rejected while unprotected");
  wp_level_a: assert property ($past(resetn) |->
    write_protected == !$past(write_protect_in))
    else $error("protect flag off its pin");
  short_ignore_a: assert property (short_low |-> deep_phy_off)
    else $error("short sense low left deep off");
  wake_exit_a: assert property (held_low |-> ##[1:3] !deep_phy_off)
    else $error("held sense low did not exit");
  phy_down_a: assert property (phy_power_down == deep_phy_off &&
    phy_keep_calibration == deep_phy_off) else $error("phy power mismatch");
  comwake_cause_a: assert property (comwake_request |->
    $past(phy_powered) && $past(phy_in_slumber)) else $error("stray comwake");
  comwake_pulse_a: assert property (comwake_request |=> !comwake_request)
    else $error("comwake longer than a cycle");
  power_hold_a: assert property ($past(resetn) |->
    device_power_hold == $past(device_power_state))
    else $error("device power touched by phy");
endmodule : sideband_checker
bind card_sideband sideband_checker #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (.*);
`default_nettype wire

/* test/host_model.sv */
// Host side of the card-sense net.
// Assumes the bench drives the PHY status lines itself.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input  wire logic       mclk,
  input  wire logic       go_deep,
  input  wire logic       phy_in_slumber,
  input  wire logic       wake_go,
  input  wire logic [7:0] wake_len,
  output var  logic       card_sense_in
);
  logic       deep     = 1'b0;
  logic [7:0] low_left = 8'h00;
  // Low by default keeps presence detection alive
  assign card_sense_in = deep && low_left == 8'h00;
  always @(posedge mclk)
  begin
    deep <= go_deep && (deep || phy_in_slumber);
    if (wake_go)
      low_left <= wake_len;
    else if (low_left != 8'h00)
      low_left <= low_left - 8'h01;
  end
endmodule : host_model
`default_nettype wire

/* test/card_sideband_pins_phy_sleep_bench.sv */
// Self-checking bench for card_sideband with the host model.
// Assumes WAKE_CYCLES shortened to 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module card_sideband_pins_phy_sleep_bench;
  import sideband_pkg::*;
  localparam int W = 8;
  logic mclk = 0, resetn = 0, go_deep = 0, wake_go = 0;
  logic drive_active_signal = 0, link_active = 0, write_cmd_valid = 0;
  logic write_protect_in = 1, phy_in_slumber = 0, phy_ready = 0;
  logic phy_powered = 0, device_power_state = 0, card_sense_in;
  logic activity_indicator_out, activity_indicator_oe, link_indicator_out;
  logic link_indicator_oe, write_reject, write_protected, deep_phy_off;
  logic phy_power_down, phy_keep_calibration, comwake_request;
  logic device_power_hold;
  logic [15:0] identify_word_161;
  logic [7:0]  wake_len = 8'h04;
  logic [4:0]  v;
  int          err_total = 0, checks = 0, n;
  card_sideband #(.WAKE_CYCLES(W)) dut_u (.*);
  host_model host_u (.*);
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [7:0] len);
    @(posedge mclk);
    wake_len <= len;
    wake_go  <= 1'b1;
    @(posedge mclk);
    wake_go  <= 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    chk(16'(deep_phy_off), 16'h1);
  endtask : pulse
  function automatic logic exp_rej(input logic [4:0] x);
    return x[2] & ~x[1];
  endfunction : exp_rej
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (2000) @(posedge mclk);
    err_total++;
    test_done;
  end
  initial
  begin
    void'($urandom(32'hC0DCA08E));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    repeat (200)
    begin
      @(posedge mclk);
      v = {drive_active_signal, link_active, write_cmd_valid,
           write_protect_in, device_power_state};
      {drive_active_signal, link_active, write_cmd_valid, write_protect_in,
       device_power_state} <= 5'($urandom);
      #1;
      chk(16'(activity_indicator_oe), 16'(v[4]));
      chk(16'(link_indicator_oe), 16'(v[3]));
      chk(16'(activity_indicator_out | link_indicator_out), 16'h0);
      chk(16'(write_reject), 16'(exp_rej(v)));
      chk(16'(write_protected), 16'(!v[1]));
      chk(16'(device_power_hold), 16'(v[0]));
    end
    chk(identify_word_161, ID_WORD_DEEP);
    $display("random pin test done");
    @(posedge mclk);
    phy_in_slumber <= 1'b1;
    go_deep        <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(16'({deep_phy_off, phy_power_down, phy_keep_calibration}),
        16'h7);
    pulse(8'h04);
    pulse(8'(W - 1));
    @(posedge mclk);
    go_deep <= 1'b0;
    n = 0;
    while (deep_phy_off === 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(n > W && n < W + 5), 16'h1);
    @(posedge mclk);
    phy_powered <= 1'b1;
    n = 0;
    while (comwake_request !== 1'b1 && n < 10)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(comwake_request), 16'h1);
    @(posedge mclk);
    phy_powered <= 1'b0;
    phy_ready   <= 1'b1;
    #1;
    chk(16'(comwake_request), 16'h0);
    repeat (2) @(posedge mclk);
    go_deep <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(16'(deep_phy_off), 16'h1);
    $display("deep power-off test done");
    test_done;
  end
endmodule : card_sideband_pins_phy_sleep_bench
`default_nettype wire
